// [src/led_channel.v]
// One LED output: source selection, stretching and combined display
`timescale 1ns/1ps
`default_nettype none
`include "phy_led_regs.vh"
module led_channel (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Configuration
  input wire [3:0] sel,
  input wire stretch_en,
  input wire [31:0] stretch_cycles,
  // Status sources
  input wire speed_100,
  input wire tx_act,
  input wire rx_act,
  input wire col_act,
  input wire link_up,
  input wire full_duplex,
  input wire fast_blink,
  input wire slow_blink,
  // LED, high means lit
  output reg led_on
);
  // ==========================================================
  // Event source for stretched selections
  reg event_in;
  reg combined;
  reg [31:0] cnt_q;
  reg [31:0] cnt_d;
  reg stretched;
  reg led_d;
  always @* begin
    combined = (sel == `SEL_LINK_RX) || (sel == `SEL_LINK_ACT) ||
      (sel == `SEL_DUP_COL);
    case (sel)
      `SEL_TX: event_in = tx_act;
      `SEL_RX: event_in = rx_act;
      `SEL_COL: event_in = col_act;
      `SEL_ACT: event_in = tx_act | rx_act;
      `SEL_LINK_RX: event_in = rx_act;
      `SEL_LINK_ACT: event_in = tx_act | rx_act;
      `SEL_DUP_COL: event_in = col_act;
      default: event_in = 1'b0;
    endcase
  end
  // ==========================================================
  // Stretch timer
  // combined always stretched
  always @* begin
    if (event_in) begin
      cnt_d = stretch_cycles;
    end else if (cnt_q != 32'h0) begin
      cnt_d = cnt_q - 32'h1;
    end else begin
      cnt_d = 32'h0;
    end
    if (combined || stretch_en) begin
      stretched = event_in || (cnt_q != 32'h0);
    end else begin
      stretched = event_in;
    end
  end
  // ==========================================================
  // Output selection
  // selector decode
  always @* begin
    case (sel)
      `SEL_SPEED: led_d = speed_100;
      `SEL_TX: led_d = stretched;
      `SEL_RX: led_d = stretched;
      `SEL_COL: led_d = stretched;
      `SEL_LINK: led_d = link_up;
      `SEL_DUPLEX: led_d = full_duplex;
      `SEL_ACT: led_d = stretched;
      `SEL_ON: led_d = 1'b1;
      `SEL_OFF: led_d = 1'b0;
      `SEL_FAST: led_d = fast_blink;
      `SEL_SLOW: led_d = slow_blink;
      `SEL_LINK_RX: led_d = link_up ^ (stretched & fast_blink);
      `SEL_LINK_ACT: led_d = link_up ^ (stretched & fast_blink);
      `SEL_DUP_COL: led_d = full_duplex ^ (stretched & fast_blink);
      // unused codes leave the LED dark
      default: led_d = 1'b0;
    endcase
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0;
      led_on <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      led_on <= led_d;
    end
  end
endmodule
`default_nettype wire

// [src/phy_led_regs.vh]
// Register offsets, field positions, reset values and timing for the block
`ifndef PHY_LED_REGS_VH
`define PHY_LED_REGS_VH
// ==========================================================
// Register offsets
`define STATUS_CHANGE_FLAGS_OFS 5'h13
`define LED_CONFIGURATION_OFS 5'h14
`define IRQ_MASK_OFS 5'h12
// ==========================================================
// Status change fields
`define AUTONEG_FINISHED_BIT 7
`define SPEED_CHANGED_BIT 6
`define DUPLEX_CHANGED_BIT 5
`define LINK_CHANGED_BIT 4
`define MGMT_IRQ_PENDING_BIT 2
// ==========================================================
// Interrupt mask fields
`define AUTONEG_MASK_BIT 7
`define SPEED_MASK_BIT 6
`define DUPLEX_MASK_BIT 5
`define LINK_MASK_BIT 4
`define GLOBAL_IRQ_ENABLE_BIT 1
`define FORCE_IRQ_BIT 0
`define IRQ_MASK_RESET 16'h0000
// ==========================================================
// LED configuration fields
`define FIRST_SEL_MSB 15
`define FIRST_SEL_LSB 12
`define SECOND_SEL_MSB 11
`define SECOND_SEL_LSB 8
`define THIRD_SEL_MSB 7
`define THIRD_SEL_LSB 4
`define STRETCH_DUR_MSB 3
`define STRETCH_DUR_LSB 2
`define STRETCH_EN_BIT 1
`define LED_CONFIGURATION_RESET 16'h0422
// ==========================================================
// Selector codes
`define SEL_SPEED 4'h0
`define SEL_TX 4'h1
`define SEL_RX 4'h2
`define SEL_COL 4'h3
`define SEL_LINK 4'h4
`define SEL_DUPLEX 4'h5
`define SEL_UNUSED_A 4'h6
`define SEL_ACT 4'h7
`define SEL_ON 4'h8
`define SEL_OFF 4'h9
`define SEL_FAST 4'hA
`define SEL_SLOW 4'hB
`define SEL_LINK_RX 4'hC
`define SEL_LINK_ACT 4'hD
`define SEL_DUP_COL 4'hE
// ==========================================================
// Timing in ms and ns, clock period in ns
`define CLOCK_PERIOD_NS 5
`define STRETCH_30_MS 30
`define STRETCH_60_MS 60
`define STRETCH_100_MS 100
`define NS_PER_MS 1000000
`define FAST_BLINK_MS 50
`define SLOW_BLINK_MS 250
`endif

// [src/phy_status_led.v]
// Status change and LED configuration registers of the PHY
`timescale 1ns/1ps
`default_nettype none
`include "phy_led_regs.vh"
module phy_status_led #(
  parameter STRETCH_30_CYC =
    `STRETCH_30_MS * (`NS_PER_MS / `CLOCK_PERIOD_NS),
  parameter STRETCH_60_CYC =
    `STRETCH_60_MS * (`NS_PER_MS / `CLOCK_PERIOD_NS),
  parameter STRETCH_100_CYC =
    `STRETCH_100_MS * (`NS_PER_MS / `CLOCK_PERIOD_NS),
  parameter FAST_HALF_CYC =
    `FAST_BLINK_MS * (`NS_PER_MS / `CLOCK_PERIOD_NS),
  parameter SLOW_HALF_CYC =
    `SLOW_BLINK_MS * (`NS_PER_MS / `CLOCK_PERIOD_NS)
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Register port
  input wire [4:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Link status, from outside the clock domain
  input wire speed_100,
  input wire full_duplex,
  input wire link_up,
  input wire autoneg_done,
  input wire tx_act,
  input wire rx_act,
  input wire col_act,
  // Outputs
  output wire mgmt_irq_n,
  output wire [1:0] led_on
);
  // ==========================================================
  // Input synchronisers
  reg [6:0] meta_q;
  reg [6:0] sync_q;
  reg [3:0] prev_q;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 7'h00;
      sync_q <= 7'h00;
      prev_q <= 4'h0;
    end else begin
      meta_q <= {col_act, rx_act, tx_act, autoneg_done, link_up,
        full_duplex, speed_100};
      sync_q <= meta_q;
      prev_q <= sync_q[3:0];
    end
  end
  // Change detection compares against the level one edge older
  wire s_speed = sync_q[0];
  wire s_duplex = sync_q[1];
  wire s_link = sync_q[2];
  wire s_an = sync_q[3];
  // ==========================================================
  // Registers
  reg speed_changed_flag_q;
  reg duplex_changed_flag_q;
  reg link_changed_flag_q;
  reg autoneg_finished_flag_q;
  reg [15:0] irq_mask_q;
  reg [15:0] led_cfg_q;
  wire stat_rd = rd && (addr == `STATUS_CHANGE_FLAGS_OFS);
  wire speed_ev = s_speed ^ prev_q[0];
  wire duplex_ev = s_duplex ^ prev_q[1];
  wire link_ev = s_link ^ prev_q[2];
  wire an_rise = s_an & ~prev_q[3];
  // ==========================================================
  // Change flags
  reg speed_changed_flag_d;
  reg duplex_changed_flag_d;
  reg link_changed_flag_d;
  reg autoneg_finished_flag_d;
  // one read clears every flag
  // Set is applied after clear, so an event in the read cycle survives
  always @* begin
    speed_changed_flag_d = speed_changed_flag_q;
    if (stat_rd) begin
      speed_changed_flag_d = 1'b0;
    end
    if (speed_ev) begin
      speed_changed_flag_d = 1'b1;
    end
    duplex_changed_flag_d = duplex_changed_flag_q;
    if (stat_rd) begin
      duplex_changed_flag_d = 1'b0;
    end
    if (duplex_ev) begin
      duplex_changed_flag_d = 1'b1;
    end
    link_changed_flag_d = link_changed_flag_q;
    if (stat_rd) begin
      link_changed_flag_d = 1'b0;
    end
    if (link_ev) begin
      link_changed_flag_d = 1'b1;
    end
    autoneg_finished_flag_d = autoneg_finished_flag_q;
    if (stat_rd) begin
      autoneg_finished_flag_d = 1'b0;
    end
    if (an_rise) begin
      autoneg_finished_flag_d = 1'b1;
    end
    // A dropped negotiation takes the bit down at once
    if (!s_an) begin
      autoneg_finished_flag_d = 1'b0;
    end
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      speed_changed_flag_q <= 1'b0;
      duplex_changed_flag_q <= 1'b0;
      link_changed_flag_q <= 1'b0;
      autoneg_finished_flag_q <= 1'b0;
    end else begin
      speed_changed_flag_q <= speed_changed_flag_d;
      duplex_changed_flag_q <= duplex_changed_flag_d;
      link_changed_flag_q <= link_changed_flag_d;
      autoneg_finished_flag_q <= autoneg_finished_flag_d;
    end
  end
  // ==========================================================
  // Writable registers
  reg [15:0] irq_mask_d;
  reg [15:0] led_cfg_d;
  always @* begin
    irq_mask_d = irq_mask_q;
    led_cfg_d = led_cfg_q;
    // Writes to read-only or unmapped offsets fall through unchanged
    if (wr && (addr == `IRQ_MASK_OFS)) begin
      irq_mask_d = wdata;
    end
    // Reserved bit 0 is kept at zero whatever is written
    if (wr && (addr == `LED_CONFIGURATION_OFS)) begin
      led_cfg_d = {wdata[15:1], 1'b0};
    end
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_mask_q <= `IRQ_MASK_RESET;
      led_cfg_q <= `LED_CONFIGURATION_RESET;
    end else begin
      irq_mask_q <= irq_mask_d;
      led_cfg_q <= led_cfg_d;
    end
  end
  // ==========================================================
  // Interrupt
  // mask and global enable
  wire irq_any = irq_mask_q[`GLOBAL_IRQ_ENABLE_BIT] & (
    (irq_mask_q[`SPEED_MASK_BIT] & speed_changed_flag_q) |
    (irq_mask_q[`DUPLEX_MASK_BIT] & duplex_changed_flag_q) |
    (irq_mask_q[`LINK_MASK_BIT] & link_changed_flag_q) |
    (irq_mask_q[`AUTONEG_MASK_BIT] & autoneg_finished_flag_q));
  // Force bit bypasses the global enable so software can test the pin
  wire irq_pend = irq_any | irq_mask_q[`FORCE_IRQ_BIT];
  assign mgmt_irq_n = ~irq_pend;
  // ==========================================================
  // Read data, one cycle after the strobe
  reg [15:0] rd_d;
  always @* begin
    rd_d = 16'h0000;
    case (addr)
      `STATUS_CHANGE_FLAGS_OFS: begin
        rd_d[`AUTONEG_FINISHED_BIT] = autoneg_finished_flag_q;
        rd_d[`SPEED_CHANGED_BIT] = speed_changed_flag_q;
        rd_d[`DUPLEX_CHANGED_BIT] = duplex_changed_flag_q;
        rd_d[`LINK_CHANGED_BIT] = link_changed_flag_q;
        rd_d[`MGMT_IRQ_PENDING_BIT] = irq_pend;
      end
      `LED_CONFIGURATION_OFS: rd_d = led_cfg_q;
      `IRQ_MASK_OFS: rd_d = irq_mask_q;
      default: rd_d = 16'h0000;
    endcase
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= rd_d;
    end else begin
      rdata <= 16'h0000;
    end
  end
  // ==========================================================
  // Blink and stretch timing
  // blink rates from the internal clock
  reg [31:0] fast_cnt_q;
  reg [31:0] slow_cnt_q;
  reg fast_q;
  reg slow_q;
  reg [31:0] fast_cnt_d;
  reg [31:0] slow_cnt_d;
  reg fast_d;
  reg slow_d;
  // Free running, so a test blink starts in whatever phase it finds
  always @* begin
    fast_cnt_d = fast_cnt_q + 32'h1;
    fast_d = fast_q;
    if (fast_cnt_q >= FAST_HALF_CYC - 1) begin
      fast_cnt_d = 32'h0;
      fast_d = ~fast_q;
    end
    slow_cnt_d = slow_cnt_q + 32'h1;
    slow_d = slow_q;
    if (slow_cnt_q >= SLOW_HALF_CYC - 1) begin
      slow_cnt_d = 32'h0;
      slow_d = ~slow_q;
    end
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fast_cnt_q <= 32'h0;
      slow_cnt_q <= 32'h0;
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      fast_cnt_q <= fast_cnt_d;
      slow_cnt_q <= slow_cnt_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
    end
  end
  // stretch duration; reserved code uses the longest
  reg [31:0] stretch_cycles;
  always @* begin
    case (led_cfg_q[`STRETCH_DUR_MSB:`STRETCH_DUR_LSB])
      2'h0: stretch_cycles = STRETCH_30_CYC;
      2'h1: stretch_cycles = STRETCH_60_CYC;
      default: stretch_cycles = STRETCH_100_CYC;
    endcase
  end
  // ==========================================================
  // LED channels
  // combined modes in each channel
  led_channel first_led (
    .clock(clock),
    .rstn(rstn),
    .sel(led_cfg_q[`FIRST_SEL_MSB:`FIRST_SEL_LSB]),
    .stretch_en(led_cfg_q[`STRETCH_EN_BIT]),
    .stretch_cycles(stretch_cycles),
    .speed_100(s_speed),
    .tx_act(sync_q[4]),
    .rx_act(sync_q[5]),
    .col_act(sync_q[6]),
    .link_up(s_link),
    .full_duplex(s_duplex),
    .fast_blink(fast_q),
    .slow_blink(slow_q),
    .led_on(led_on[0])
  );
  led_channel second_led (
    .clock(clock),
    .rstn(rstn),
    .sel(led_cfg_q[`SECOND_SEL_MSB:`SECOND_SEL_LSB]),
    .stretch_en(led_cfg_q[`STRETCH_EN_BIT]),
    .stretch_cycles(stretch_cycles),
    .speed_100(s_speed),
    .tx_act(sync_q[4]),
    .rx_act(sync_q[5]),
    .col_act(sync_q[6]),
    .link_up(s_link),
    .full_duplex(s_duplex),
    .fast_blink(fast_q),
    .slow_blink(slow_q),
    .led_on(led_on[1])
  );
endmodule
`default_nettype wire

// [tb/mgmt_station.sv]
// Management station model driving the register port
`timescale 1ns/1ps
`default_nettype none
module mgmt_station (
  // Clock
  input wire logic clock,
  // Register port
  output logic [4:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One bus cycle; q is the answer standing after the previous cycle
  task cyc(input logic w, input logic r, input logic [4:0] a,
    input logic [15:0] d, output logic [15:0] q);
    begin
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      q = rdata;
    end
  endtask
  task wr16(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    begin
      cyc(1'b1, 1'b0, a, d, q);
      cyc(1'b0, 1'b0, a, 16'h0000, q);
    end
  endtask
  task rd16(input logic [4:0] a, output logic [15:0] q);
    begin
      cyc(1'b0, 1'b1, a, 16'h0000, q);
      cyc(1'b0, 1'b0, a, 16'h0000, q);
    end
  endtask
endmodule
`default_nettype wire

// [tb/phy_status_led_checker.sv]
// Port assertions for the status change and LED register block
`timescale 1ns/1ps
`default_nettype none
module phy_status_led_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Status levels and outputs
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic link_up,
  input wire logic autoneg_done,
  input wire logic mgmt_irq_n,
  input wire logic [1:0] led_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ====================
  // Calm tracking: a level change takes a few edges to reach the
  // flags, so a clearing read is judged only once levels settled
  logic [3:0] lvl_q, calm_q;
  wire logic [3:0] lvl = {autoneg_done, speed_100, full_duplex, link_up};
  wire logic calm = calm_q > 4'h7;
  wire logic rs = rd && addr == 5'h13;
  wire logic wl = wr && addr == 5'h14;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lvl_q <= 4'h0;
      calm_q <= 4'h0;
    end else begin
      lvl_q <= lvl;
      if (lvl != lvl_q) calm_q <= 4'h0;
      else if (calm_q != 4'hF) calm_q <= calm_q + 4'h1;
    end
  end
  // ====================
  // Assertions
  a_idle_rdata_zero: assert property (
    !rd |=> rdata == 16'h0000) else $error("rdata not idle zero");
  a_unmapped_read_zero: assert property (
    rd && (addr < 5'h12 || addr > 5'h14) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_reserved_zero: assert property (
    rs |=> rdata[15:8] == 8'h00 && rdata[3] == 1'b0 && rdata[1:0] == 2'h0)
    else $error("status reserved bits set");
  a_pending_matches_pin: assert property (
    rs |=> rdata[2] == !$past(mgmt_irq_n)) else $error("pending bit wrong");
  a_led_cfg_readback: assert property (
    wl ##1 (rd && addr == 5'h14) |=> rdata == ($past(wdata, 2) & 16'hFFFE))
    else $error("led cfg readback wrong");
  a_second_read_clear: assert property (
    rs ##1 (rs && calm) |=> rdata[7:4] == 4'h0)
    else $error("flags not cleared by read");
  a_autoneg_low_zero: assert property (
    rs && calm && !autoneg_done |=> !rdata[7])
    else $error("autoneg bit set while not done");
  a_test_on_first: assert property (
    wl && wdata[15:12] == 4'h8 |-> ##3 led_on[0])
    else $error("first led not forced on");
  a_test_off_second: assert property (
    wl && wdata[11:8] == 4'h9 |-> ##3 !led_on[1])
    else $error("second led not forced off");
  c_double_read: cover property (rs ##1 rs);
  c_led_write: cover property (wl);
  c_irq_low: cover property (!mgmt_irq_n);
endmodule
bind phy_status_led phy_status_led_checker chk (.clock(clock),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .speed_100(speed_100), .full_duplex(full_duplex),
  .link_up(link_up), .autoneg_done(autoneg_done),
  .mgmt_irq_n(mgmt_irq_n), .led_on(led_on));
`default_nettype wire

// [tb/phy_status_led_tb_top.sv]
// Self-checking bench for the status change and LED register block
`timescale 1ns/1ps
`default_nettype none
`include "phy_led_regs.vh"
module phy_status_led_tb_top;
  // ====================
  // Signals
  localparam logic [4:0] SC = `STATUS_CHANGE_FLAGS_OFS;
  localparam logic [4:0] LC = `LED_CONFIGURATION_OFS;
  localparam logic [4:0] IM = `IRQ_MASK_OFS;
  logic clock, rstn, sp, fd, lk, an, tx, rx, co;
  wire logic [4:0] addr;
  wire logic [15:0] wdata, rdata;
  wire logic wr, rd, irq_n;
  wire logic [1:0] led;
  logic [15:0] q, m, e, d;
  logic [3:0] o, v;
  integer seed, mismatches, n_tests, i, j, t;
  // Short counts keep the stretch and blink checks quick
  phy_status_led #(.STRETCH_30_CYC(20), .STRETCH_60_CYC(40),
    .STRETCH_100_CYC(60), .FAST_HALF_CYC(4), .SLOW_HALF_CYC(8)) dut (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .speed_100(sp), .full_duplex(fd),
    .link_up(lk), .autoneg_done(an), .tx_act(tx), .rx_act(rx),
    .col_act(co), .mgmt_irq_n(irq_n), .led_on(led));
  mgmt_station mst (.clock(clock), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  // ====================
  // Helpers
  task cmp(input string nm, input logic [15:0] x, input logic [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %s exp %h got %h", nm, x, g);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  function logic [15:0] exp_sts(input logic [3:0] p, input logic [3:0] n,
    input logic [15:0] k);
    logic [3:0] f;
    logic g;
    begin
      f = {n[3] & ~p[3], n[2:0] ^ p[2:0]};
      g = (k[1] & |(f & k[7:4])) | k[0];
      exp_sts = {8'h00, f, 1'b0, g, 2'h0};
    end
  endfunction
  function logic exp_led(input logic [3:0] c, input logic [5:0] r);
    case (c)
      4'h0: exp_led = r[5];
      4'h1: exp_led = r[2];
      4'h2: exp_led = r[1];
      4'h3: exp_led = r[0];
      4'h4, 4'hC, 4'hD: exp_led = r[3];
      4'h5, 4'hE: exp_led = r[4];
      4'h7: exp_led = r[2] | r[1];
      4'h8: exp_led = 1'b1;
      default: exp_led = 1'b0;
    endcase
  endfunction
  // ====================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #100000;
    mismatches = mismatches + 1;
    end_sim;
  end
  // ====================
  // Scenarios
  initial begin
    seed = 32'h8012;
    mismatches = 0;
    n_tests = 0;
    rstn = 1'b0;
    {sp, fd, lk, an, tx, rx, co} = 7'h00;
    o = 4'h0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    mst.rd16(LC, q);
    cmp("led cfg reset", `LED_CONFIGURATION_RESET, q);
    mst.rd16(IM, q);
    cmp("mask reset", `IRQ_MASK_RESET, q);
    mst.wr16(SC, 16'hFFFF);
    mst.rd16(SC, q);
    cmp("status ro", 16'h0000, q);
    mst.rd16(5'h1F, q);
    cmp("unmapped", 16'h0000, q);
    for (i = 0; i < 24; i = i + 1) begin
      m = $random(seed) & 16'h00F3;
      v = $random(seed);
      mst.wr16(IM, m);
      {an, sp, fd, lk} <= v;
      repeat (8) @(posedge clock);
      e = exp_sts(o, v, m);
      cmp("irq pin", {15'h0, ~e[2]}, {15'h0, irq_n});
      cmp("default leds", {14'h0, v[0], v[2]}, {14'h0, led});
      mst.cyc(1'b0, 1'b1, SC, 16'h0000, q);
      mst.cyc(1'b0, 1'b1, SC, 16'h0000, q);
      cmp("status", e, q);
      mst.cyc(1'b0, 1'b0, SC, 16'h0000, q);
      cmp("status reread", exp_sts(v, v, m), q);
      o = v;
    end
    for (i = 0; i < 4; i = i + 1) begin
      d = $random(seed);
      mst.cyc(1'b1, 1'b0, LC, d, q);
      mst.cyc(1'b0, 1'b1, LC, 16'h0000, q);
      mst.cyc(1'b0, 1'b0, LC, 16'h0000, q);
      cmp("led cfg", d & 16'hFFFE, q);
    end
    for (i = 0; i < 16; i = i + 1) begin
      d = $random(seed);
      // Quiet activity from the slow blink step on: a stale receive
      // pulse would otherwise stretch into the first combined check
      if (i > 10) d[2:0] = 3'h0;
      {sp, fd, lk, tx, rx, co} <= d[5:0];
      mst.wr16(LC, {i[3:0], i[3:0], 8'h20});
      repeat (8) @(posedge clock);
      if (i == 10 || i == 11) begin
        t = 0;
        for (j = 0; j < 64; j = j + 1) begin
          e[0] = led[0];
          @(posedge clock);
          if (led[0] !== e[0]) t = t + 1;
        end
        j = (i == 10) ? 16 : 8;
        cmp("blink", 16'h0001, {15'h0, t > j - 2 && t < j + 2});
      end else begin
        cmp("led pair", {14'h0, {2{exp_led(i[3:0], d[5:0])}}},
          {14'h0, led});
      end
    end
    {sp, fd, lk, tx, rx, co} <= 6'h00;
    for (i = 0; i < 5; i = i + 1) begin
      t = (i[1:0] == 2'h0) ? 20 : (i == 1) ? 40 : 60;
      mst.wr16(LC, {8'h12, 4'h2, i[1:0], i < 4, 1'b0});
      tx <= 1'b1;
      rx <= 1'b1;
      @(posedge clock);
      tx <= 1'b0;
      rx <= 1'b0;
      repeat (t - 6) @(posedge clock);
      cmp("stretched", {14'h0, {2{i < 4}}}, {14'h0, led});
      repeat (14) @(posedge clock);
      cmp("stretch end", 16'h0000, {14'h0, led});
    end
    for (i = 0; i < 3; i = i + 1) begin
      {lk, fd} <= {i != 1, 1'b1};
      mst.wr16(LC, {4'hC + i[3:0], 12'h220});
      repeat (6) @(posedge clock);
      cmp("combined base", {15'h0, i != 1}, {15'h0, led[0]});
      {tx, rx, co} <= {i == 1, i == 0, i == 2};
      @(posedge clock);
      {tx, rx, co} <= 3'h0;
      t = 0;
      repeat (24) begin
        @(posedge clock);
        if (led[0] !== (i != 1)) t = t + 1;
      end
      cmp("combined blink", 16'h0001, {15'h0, t > 0});
    end
    end_sim;
  end
endmodule
`default_nettype wire
